// File: dtb_defs.svh
// Register offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DTB_DEFS_SVH
`define DTB_DEFS_SVH
`define DTB_OFS_MODE 8'h00
`define DTB_OFS_FUNC 8'h04
`define DTB_OFS_CTRL0 8'h08
`define DTB_OFS_CTRL1 8'h0c
`define DTB_OFS_IOCTL 8'h10
`define DTB_OFS_CNT0 8'h14
`define DTB_OFS_CNT1 8'h18
`define DTB_OFS_GR_BASE 8'h20
`define DTB_OFS_GR_LAST 8'h3c
`define DTB_OFS_STAT 8'h40
`define DTB_OFS_MASK 8'h44
`define DTB_OFS_OER1 8'h48
`define DTB_OFS_OER2 8'h4c
`define DTB_OFS_EXTIRQ 8'h50
`define DTB_CLR_NONE 3'h0
`define DTB_CLR_CAPTURE 3'h1
`define DTB_CLR_SYNC 3'h3
`define DTB_CTRL_START 7
`define DTB_ST_OVF 4
`define DTB_ST_CH1 8
`define DTB_ST_CUT 16
`define DTB_OER1_RESET 8'hff
`define DTB_CNT_MAX 16'hffff
`define DTB_CUT_DELAY_NS 100
`define DTB_CLK_NS 100
`define DTB_CUT_CYCLES (`DTB_CUT_DELAY_NS / `DTB_CLK_NS)
`endif

// File: dtb_pkg.sv
// Types shared by the dual timer block
package dtb_pkg;
  typedef enum logic [1:0] {
    FM_TIMER,
    FM_RESET_SYNC,
    FM_COMPL,
    FM_SHARED
  } dtb_fmode_t;
  typedef struct packed {
    logic [1:0] buffer_d_select;
    logic [1:0] buffer_c_select;
    logic sync;
  } dtb_mode_t;
  typedef struct packed {
    logic shared_period_pwm_mode;
    logic [1:0] cmd;
  } dtb_func_t;
  typedef struct packed {
    logic [1:0] ext_irq0_filter_field;
    logic irq_request_flag;
    logic irq_polarity_select;
    logic ext_irq0_both_edges;
    logic ext_irq0_input_enable;
  } dtb_extirq_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } dtb_aphase_t;
endpackage

// File: dtb_timer.sv
// Buffer transfer, synchronous preset and clear, and pulse output cutoff of a two-channel timer
`timescale 1ns/10ps
`include "dtb_defs.svh"
module dtb_timer
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Timer pins, index ch*4 + A,B,C,D
  input wire logic [7:0] timer_io_in,
  output logic [7:0] timer_io_out,
  output logic [7:0] timer_io_oe_n,
  // Cutoff pin and interrupt
  input wire logic cutoff_pin_n,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  dtb_pkg::dtb_aphase_t aph;
  dtb_pkg::dtb_mode_t timer_mode_reg;
  dtb_pkg::dtb_func_t function_control_reg;
  dtb_pkg::dtb_extirq_t ext_irq0_control_reg;
  logic [7:0] timer_control_reg [2];
  logic [7:0] io_control_reg;
  logic [15:0] cnt [2];
  logic [15:0] gr [2][4];
  logic [16:0] timer_status_reg;
  logic [16:0] irq_mask;
  logic [7:0] output_enable_reg1;
  logic cutoff_input_enable;
  logic [7:0] pin_prev;
  logic cut_prev;
  logic [7:0] wave;
  logic [15:0] next_cnt [2];
  logic [15:0] next_gr [2][4];
  logic [16:0] st_set;
  logic [3:0] cap_ev [2];
  logic [3:0] match [2];
  logic [1:0] load_a;
  logic [1:0] load_b;
  logic [1:0] own_clr;
  logic [1:0] clr;
  logic uflow1;
  logic [7:0] wave_tgl;
  dtb_pkg::dtb_fmode_t fmode;
  // Address decode
  wire take = hsel & hready & htrans[1];
  wire wr = aph.valid & aph.write;
  wire [7:0] wa = aph.addr;
  wire wr_cnt0 = wr & (wa == `DTB_OFS_CNT0);
  wire wr_cnt1 = wr & (wa == `DTB_OFS_CNT1);
  wire wr_gr = wr & (wa >= `DTB_OFS_GR_BASE) & (wa <= `DTB_OFS_GR_LAST);
  wire [2:0] wr_gidx = 3'((wa - `DTB_OFS_GR_BASE) >> 2);
  wire wr_oer1 = wr & (wa == `DTB_OFS_OER1);
  wire wr_ext = wr & (wa == `DTB_OFS_EXTIRQ);
  wire rd_stat = take & ~hwrite & (haddr[7:0] == `DTB_OFS_STAT);
  wire [2:0] rd_gidx = 3'((haddr[7:0] - `DTB_OFS_GR_BASE) >> 2);
  wire cut_now = cutoff_input_enable & ~cutoff_pin_n;
  wire cut_edge = ext_irq0_control_reg.irq_polarity_select ? (cutoff_pin_n & ~cut_prev) : (~cutoff_pin_n & cut_prev);
  wire cut_any = cutoff_pin_n ^ cut_prev;
  wire ext_req = ext_irq0_control_reg.ext_irq0_input_enable &
                 (ext_irq0_control_reg.ext_irq0_both_edges ? cut_any : cut_edge);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(timer_status_reg & irq_mask);
  ////////////////////////////////////////////////////////////////////////////
  // Mode from function control; complementary outranks reset-synchronous
  assign fmode = function_control_reg.cmd[1] ? dtb_pkg::FM_COMPL :
                 function_control_reg.cmd[0] ? dtb_pkg::FM_RESET_SYNC :
                 function_control_reg.shared_period_pwm_mode ? dtb_pkg::FM_SHARED : dtb_pkg::FM_TIMER;
  // Counter 1 runs down in complementary mode, so underflow is its wrap
  assign uflow1 = (fmode == dtb_pkg::FM_COMPL) & timer_control_reg[1][`DTB_CTRL_START] & (cnt[1] == 16'h0000);
  // Sync clear follows the other channel's own clear
  assign own_clr[0] = (timer_control_reg[0][2:0] == `DTB_CLR_CAPTURE) & (|cap_ev[0]);
  assign own_clr[1] = (timer_control_reg[1][2:0] == `DTB_CLR_CAPTURE) & (|cap_ev[1]);
  assign clr[0] = own_clr[0] | (timer_mode_reg.sync & (timer_control_reg[0][2:0] == `DTB_CLR_SYNC) & own_clr[1]);
  assign clr[1] = own_clr[1] | (timer_mode_reg.sync & (timer_control_reg[1][2:0] == `DTB_CLR_SYNC) & own_clr[0]);
  // Output enable low only with timer output allowed and pin not a capture input
  assign timer_io_oe_n = output_enable_reg1 | io_control_reg;
  assign timer_io_out = wave;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        cap_ev[ch][j] = io_control_reg[ch*4+j] & timer_io_in[ch*4+j] & ~pin_prev[ch*4+j];
        match[ch][j] = ~io_control_reg[ch*4+j] & timer_control_reg[ch][`DTB_CTRL_START] & (cnt[ch] == gr[ch][j]);
      end
    end
    // Buffer reload events per mode
    load_a = '0;
    load_b = '0;
    case (fmode)
      dtb_pkg::FM_TIMER:
      begin
        for (int ch = 0; ch < 2; ch++)
        begin
          load_a[ch] = timer_mode_reg.buffer_c_select[ch] & match[ch][0];
          load_b[ch] = timer_mode_reg.buffer_d_select[ch] & match[ch][1];
        end
      end
      dtb_pkg::FM_RESET_SYNC:
      begin
        load_a = timer_mode_reg.buffer_c_select & {2{match[0][0]}};
        load_b = timer_mode_reg.buffer_d_select & {2{match[0][0]}};
      end
      dtb_pkg::FM_COMPL:
      begin
        load_a = timer_mode_reg.buffer_c_select & {match[0][0] | uflow1, 1'b0};
        load_b = timer_mode_reg.buffer_d_select & {2{match[0][0] | uflow1}};
      end
      default:
      begin
        load_a = timer_mode_reg.buffer_c_select & {2{match[0][0]}};
        load_b = timer_mode_reg.buffer_d_select & {2{match[0][0]}};
      end
    endcase
    st_set = '0;
    wave_tgl = '0;
    st_set[`DTB_ST_CUT] = cut_now & ~(&output_enable_reg1);
    for (int ch = 0; ch < 2; ch++)
    begin
      // Counter: software write wins over count and clear
      if (ch == 0 ? (wr_cnt0 | (timer_mode_reg.sync & wr_cnt1)) : (wr_cnt1 | (timer_mode_reg.sync & wr_cnt0)))
        next_cnt[ch] = hwdata[15:0];
      else if (clr[ch])
        next_cnt[ch] = 16'h0000;
      else if (!timer_control_reg[ch][`DTB_CTRL_START])
        next_cnt[ch] = cnt[ch];
      else if (ch == 1 && fmode == dtb_pkg::FM_COMPL)
        next_cnt[ch] = cnt[ch] - 16'h0001;
      else
        next_cnt[ch] = cnt[ch] + 16'h0001;
      // A and B: capture stores the count, reload takes the buffer
      for (int j = 0; j < 2; j++)
      begin
        if (wr_gr && wr_gidx == 3'(ch*4+j))
          next_gr[ch][j] = hwdata[15:0];
        else if (cap_ev[ch][j])
          next_gr[ch][j] = cnt[ch];
        else if (j == 0 ? load_a[ch] : load_b[ch])
          next_gr[ch][j] = gr[ch][j+2];
        else
          next_gr[ch][j] = gr[ch][j];
      end
      // C and D: buffering moves the old A or B in before it is overwritten
      for (int j = 2; j < 4; j++)
      begin
        if (wr_gr && wr_gidx == 3'(ch*4+j))
          next_gr[ch][j] = hwdata[15:0];
        else if ((j == 2 ? timer_mode_reg.buffer_c_select[ch] : timer_mode_reg.buffer_d_select[ch]) && cap_ev[ch][j-2])
          next_gr[ch][j] = gr[ch][j-2];
        else if (cap_ev[ch][j])
          next_gr[ch][j] = cnt[ch];
        else
          next_gr[ch][j] = gr[ch][j];
      end
      // Flags
      st_set[ch*8+0] = cap_ev[ch][0] | match[ch][0];
      st_set[ch*8+1] = cap_ev[ch][1] | match[ch][1];
      if (timer_mode_reg.buffer_c_select[ch])
        st_set[ch*8+2] = io_control_reg[ch*4] ? cap_ev[ch][2] : match[ch][0];
      else
        st_set[ch*8+2] = cap_ev[ch][2] | match[ch][2];
      if (timer_mode_reg.buffer_d_select[ch])
        st_set[ch*8+3] = io_control_reg[ch*4+1] ? cap_ev[ch][2] : match[ch][1];
      else
        st_set[ch*8+3] = cap_ev[ch][3] | match[ch][3];
      st_set[ch*8+`DTB_ST_OVF] = timer_control_reg[ch][`DTB_CTRL_START] & ~(ch == 1 && fmode == dtb_pkg::FM_COMPL) &
                                 (cnt[ch] == `DTB_CNT_MAX);
      for (int j = 0; j < 4; j++)
        wave_tgl[ch*4+j] = match[ch][j];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data registered into the data phase, unmapped reads zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `DTB_OFS_MODE)
      rd_mux = 32'(timer_mode_reg);
    else if (haddr[7:0] == `DTB_OFS_FUNC)
      rd_mux = 32'(function_control_reg);
    else if (haddr[7:0] == `DTB_OFS_CTRL0)
      rd_mux = 32'(timer_control_reg[0]);
    else if (haddr[7:0] == `DTB_OFS_CTRL1)
      rd_mux = 32'(timer_control_reg[1]);
    else if (haddr[7:0] == `DTB_OFS_IOCTL)
      rd_mux = 32'(io_control_reg);
    else if (haddr[7:0] == `DTB_OFS_CNT0)
      rd_mux = 32'(cnt[0]);
    else if (haddr[7:0] == `DTB_OFS_CNT1)
      rd_mux = 32'(cnt[1]);
    else if (haddr[7:0] >= `DTB_OFS_GR_BASE && haddr[7:0] <= `DTB_OFS_GR_LAST)
      rd_mux = 32'(gr[rd_gidx[2]][rd_gidx[1:0]]);
    else if (haddr[7:0] == `DTB_OFS_STAT)
      rd_mux = 32'(timer_status_reg);
    else if (haddr[7:0] == `DTB_OFS_MASK)
      rd_mux = 32'(irq_mask);
    else if (haddr[7:0] == `DTB_OFS_OER1)
      rd_mux = 32'(output_enable_reg1);
    else if (haddr[7:0] == `DTB_OFS_OER2)
      rd_mux = 32'(cutoff_input_enable);
    else if (haddr[7:0] == `DTB_OFS_EXTIRQ)
      rd_mux = 32'(ext_irq0_control_reg);
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      aph <= '0;
      hrdata <= 32'h0000_0000;
      timer_mode_reg <= '0;
      function_control_reg <= '0;
      timer_control_reg <= '{default: 8'h00};
      io_control_reg <= 8'h00;
      irq_mask <= '0;
      cutoff_input_enable <= 1'b0;
    end
    else
    begin
      aph <= '{valid: take, write: hwrite, addr: haddr[7:0]};
      hrdata <= (take && !hwrite) ? rd_mux : 32'h0000_0000;
      if (wr && wa == `DTB_OFS_MODE)
        timer_mode_reg <= dtb_pkg::dtb_mode_t'(hwdata[4:0]);
      if (wr && wa == `DTB_OFS_FUNC)
        function_control_reg <= dtb_pkg::dtb_func_t'(hwdata[2:0]);
      if (wr && wa == `DTB_OFS_CTRL0)
        timer_control_reg[0] <= hwdata[7:0];
      if (wr && wa == `DTB_OFS_CTRL1)
        timer_control_reg[1] <= hwdata[7:0];
      if (wr && wa == `DTB_OFS_IOCTL)
        io_control_reg <= hwdata[7:0];
      if (wr && wa == `DTB_OFS_MASK)
        irq_mask <= hwdata[16:0];
      if (wr && wa == `DTB_OFS_OER2)
        cutoff_input_enable <= hwdata[0];
    end
  end
  // Hardware state; every set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cnt <= '{default: 16'h0000};
      gr <= '{default: '{default: 16'hffff}};
      timer_status_reg <= '0;
      output_enable_reg1 <= `DTB_OER1_RESET;
      ext_irq0_control_reg <= '0;
      pin_prev <= 8'h00;
      cut_prev <= 1'b1;
      wave <= 8'h00;
    end
    else
    begin
      cnt <= next_cnt;
      gr <= next_gr;
      pin_prev <= timer_io_in;
      cut_prev <= cutoff_pin_n;
      wave <= wave ^ wave_tgl;
      timer_status_reg <= (rd_stat ? 17'h00000 : timer_status_reg) | st_set;
      // Cutoff beats a software enable; nothing but software clears it
      output_enable_reg1 <= cut_now ? `DTB_OER1_RESET : (wr_oer1 ? hwdata[7:0] : output_enable_reg1);
      if (wr_ext)
        ext_irq0_control_reg <= dtb_pkg::dtb_extirq_t'(hwdata[5:0] | {2'b00, ext_req, 3'b000});
      else if (ext_req)
        ext_irq0_control_reg.irq_request_flag <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence cut_seen;
    cutoff_input_enable && !cutoff_pin_n;
  endsequence
  sequence pins_released;
    ##[1:2] (timer_io_oe_n == 8'hff);
  endsequence
  buf_capture_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (timer_mode_reg.buffer_c_select[0] && cap_ev[0][0] && !wr_gr) |=> (gr[0][2] == $past(gr[0][0])))
    else $error("capture did not move old A into buffer");
  compare_load_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (fmode == dtb_pkg::FM_TIMER && timer_mode_reg.buffer_c_select[1] && match[1][0] && !wr_gr && !cap_ev[1][0])
    |=> (gr[1][0] == $past(gr[1][2])))
    else $error("compare match did not reload A from buffer");
  shared_load_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (fmode == dtb_pkg::FM_SHARED && timer_mode_reg.buffer_d_select[1] && match[0][0] && !wr_gr && !cap_ev[1][1])
    |=> (gr[1][1] == $past(gr[1][3])))
    else $error("shared period match did not reload B1");
  compl_a0_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (fmode == dtb_pkg::FM_COMPL && !wr_gr && !cap_ev[0][0]) |=> (gr[0][0] == $past(gr[0][0])))
    else $error("complementary mode touched A0");
  sync_write_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (timer_mode_reg.sync && (wr_cnt0 || wr_cnt1)) |=> (cnt[0] == cnt[1]) && (cnt[0] == $past(hwdata[15:0])))
    else $error("lockstep write did not reach both counters");
  sync_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (timer_mode_reg.sync && timer_control_reg[1][2:0] == `DTB_CLR_SYNC && own_clr[0] && !wr_cnt0 && !wr_cnt1)
    |=> (cnt[1] == 16'h0000) && (cnt[0] == 16'h0000))
    else $error("synchronous clear missed");
  cap_clear_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (own_clr[0] && !wr_cnt0 && !wr_cnt1) |=> (cnt[0] == 16'h0000))
    else $error("capture clear missed");
  oe_gate_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (wr_oer1 && !cut_now) |=> (timer_io_oe_n == ($past(hwdata[7:0]) | io_control_reg)))
    else $error("pin enables do not follow the output enable write");
  cutoff_set_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    cut_seen |=> (output_enable_reg1 == `DTB_OER1_RESET))
    else $error("cutoff did not disable outputs");
  cutoff_pins_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    cut_seen |-> pins_released)
    else $error("pins not released within two cycles");
  cutoff_hold_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (output_enable_reg1 == `DTB_OER1_RESET && !wr_oer1) |=> (output_enable_reg1 == `DTB_OER1_RESET))
    else $error("output enables restored without software");
  irq_flag_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    ext_req |=> ext_irq0_control_reg.irq_request_flag)
    else $error("cutoff pin change did not set request flag");
endmodule

// File: dtb_pins_model.sv
// Pin-side model: waveform pin levels and the cutoff input
`timescale 1ns/10ps
module dtb_pins_model
(
  // Clock
  input wire logic mclk,
  // Bench requests
  input wire logic [7:0] edge_req,
  input wire logic cut_req,
  // Timer pins
  input wire logic [7:0] timer_io_out,
  input wire logic [7:0] timer_io_oe_n,
  output logic [7:0] timer_io_in,
  // Cutoff pin
  output logic cutoff_pin_n
);
  logic [7:0] ext_lvl = 8'h00;
  // Registered so a request shows as one clean rising edge
  always @(posedge mclk) ext_lvl <= edge_req;
  // Block drives the pin only while its enable is low
  assign timer_io_in = (timer_io_oe_n & ext_lvl) | (~timer_io_oe_n & timer_io_out);
  // Held high between cutoff events, input mode
  assign cutoff_pin_n = ~cut_req;
endmodule

// File: dual_timer_buffer_sync_cutoff_test.sv
// Self-checking testbench of the dual timer block
`timescale 1ns/10ps
module dual_timer_buffer_sync_cutoff_test;
  logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, irq, cutoff_pin_n, cut_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] timer_io_in, timer_io_out, timer_io_oe_n, edge_req;
  int num_errors = 0;
  int n_compared = 0;
  dtb_timer DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_io_in(timer_io_in), .timer_io_out(timer_io_out),
    .timer_io_oe_n(timer_io_oe_n), .cutoff_pin_n(cutoff_pin_n), .irq(irq));
  dtb_pins_model pins (.mclk(mclk), .edge_req(edge_req), .cut_req(cut_req), .timer_io_out(timer_io_out),
    .timer_io_oe_n(timer_io_oe_n), .timer_io_in(timer_io_in), .cutoff_pin_n(cutoff_pin_n));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("ERROR timeout expected done seen hang");
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic pulse(input logic [7:0] b);
    edge_req <= b;
    repeat (2) @(posedge mclk);
    edge_req <= 8'h00;
    repeat (4) @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("oe_n reset", 32'hff, {24'h0, timer_io_oe_n});
    chk("out reset", 32'h0, {24'h0, timer_io_out});
    rdc("oer1 reset", 8'h48, 32'hff, 32'hffffffff);
    rdc("gra0 reset", 8'h20, 32'hffff, 32'hffffffff);
    wr(8'h60, 32'h5a5a);
    rdc("unmapped", 8'h60, 32'h0, 32'hffffffff);
    $display("done reset");
  endtask
  // Both C and D buffer on channel 0, so a C pin edge must raise both flags
  task automatic t_capture();
    wr(8'h10, 32'h0f);
    wr(8'h00, 32'h0a);
    wr(8'h20, 32'h1234);
    wr(8'h14, 32'h0100);
    wr(8'h08, 32'h81);
    pulse(8'h01);
    wr(8'h08, 32'h01);
    rdc("grc0", 8'h28, 32'h1234, 32'hffff);
    rdc("cnt0 cleared", 8'h14, 32'h0, 32'hffc0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h44, 32'h0c);
    pulse(8'h04);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("flags cd", 8'h40, 32'hc, 32'hc);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("done capture");
  endtask
  task automatic t_compare();
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h04);
    wr(8'h30, 32'h10);
    wr(8'h38, 32'h50);
    wr(8'h18, 32'h0);
    wr(8'h44, 32'h400);
    wr(8'h48, 32'hef);
    @(posedge mclk);
    chk("oe_n", 32'hef, {24'h0, timer_io_oe_n});
    wr(8'h0c, 32'h80);
    repeat (40) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    chk("wave", 32'h10, {24'h0, timer_io_out});
    wr(8'h0c, 32'h0);
    rdc("gra1", 8'h30, 32'h50, 32'hffff);
    rdc("flag c1", 8'h40, 32'h400, 32'h400);
    wr(8'h44, 32'h0);
    $display("done compare");
  endtask
  // Reset-sync, complementary and shared-period reload on counter 0 matching A0
  task automatic t_modes();
    logic [7:0] tg [3] = '{8'h24, 8'h30, 8'h34};
    logic [31:0] v;
    wr(8'h00, 32'h1e);
    for (int k = 0; k < 3; k++)
    begin
      v = 32'h0a00 + 32'(k * 16);
      wr(8'h04, 32'h1 << k);
      wr(8'h14, 32'h0);
      wr(8'h20, 32'h20);
      wr(8'h28, 32'h20);
      for (int j = 0; j < 3; j++)
      begin
        wr(tg[j], 32'h0111);
        wr(tg[j] + 8'h08, v + 32'(j));
      end
      wr(8'h08, 32'h80);
      repeat (50) @(posedge mclk);
      wr(8'h08, 32'h0);
      for (int j = 0; j < 3; j++)
        rdc("reloaded", tg[j], v + 32'(j), 32'hffff);
    end
    wr(8'h04, 32'h0);
    $display("done modes");
  endtask
  task automatic t_lockstep();
    wr(8'h00, 32'h01);
    wr(8'h14, 32'h1000);
    rdc("cnt1 preset", 8'h18, 32'h1000, 32'hffff);
    wr(8'h18, 32'h2000);
    rdc("cnt0 preset", 8'h14, 32'h2000, 32'hffff);
    wr(8'h10, 32'h01);
    wr(8'h0c, 32'h83);
    wr(8'h08, 32'h81);
    pulse(8'h01);
    rdc("cnt1 sync clear", 8'h18, 32'h0, 32'hffc0);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h0);
    $display("done lockstep");
  endtask
  task automatic t_cutoff();
    wr(8'h10, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'h50, 32'h01);
    wr(8'h4c, 32'h01);
    @(posedge mclk);
    chk("oe_n on", 32'h0, {24'h0, timer_io_oe_n});
    cut_req <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("oe_n cut", 32'hff, {24'h0, timer_io_oe_n});
    cut_req <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc("oer1 held", 8'h48, 32'hff, 32'hff);
    rdc("irq flag", 8'h50, 32'h8, 32'h8);
    wr(8'h48, 32'h0);
    @(posedge mclk);
    chk("oe_n back", 32'h0, {24'h0, timer_io_oe_n});
    $display("done cutoff");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, edge_req, cut_req} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_capture();
    t_compare();
    t_modes();
    t_lockstep();
    t_cutoff();
    close_out();
  end
endmodule
